// *** scpi_status_pkg.sv ***
package scpi_status_pkg;

	// ----------------------------------------
	// widths and group count
	// ----------------------------------------
	localparam int DATA_W = 16;
	localparam int GROUPS = 7;

	typedef logic [DATA_W-1:0] word_t;

	// ----------------------------------------
	// group select codes
	// ----------------------------------------
	localparam logic [2:0] GRP_ULF = 3'h0; // upper limit fail
	localparam logic [2:0] GRP_CALOP = 3'h1; // calibrating operation
	localparam logic [2:0] GRP_DEV = 3'h2; // device group
	localparam logic [2:0] GRP_QCAL = 3'h3; // questionable calibration
	localparam logic [2:0] GRP_QPOW = 3'h4; // questionable power
	localparam logic [2:0] GRP_QUESTIONABLE_GROUP = 3'h5; // questionable summary
	localparam logic [2:0] GRP_OPERATION_GROUP = 3'h6; // operation summary

	// ----------------------------------------
	// field select codes within a group
	// ----------------------------------------
	localparam logic [2:0] FLD_CONDITION_VIEW = 3'h0; // condition view, query only
	localparam logic [2:0] FLD_EVENT = 3'h1; // event latch, read clears
	localparam logic [2:0] FLD_MASK = 3'h2; // event mask
	localparam logic [2:0] FLD_RISE = 3'h3; // rising filter
	localparam logic [2:0] FLD_FALL = 3'h4; // falling filter

	// ----------------------------------------
	// value limits and reset values
	// ----------------------------------------
	localparam word_t WRITE_KEEP = 16'h7fff; // top bit always zero
	localparam word_t RISE_RST = 16'h7fff;
	localparam word_t FALL_RST = 16'h0000;
	localparam word_t MASK_RST = 16'h0000;
	localparam word_t EVENT_RST = 16'h0000;

	// ----------------------------------------
	// bits in use per group
	// ----------------------------------------
	localparam word_t ULF_USED = 16'h0078;
	localparam word_t CALOP_USED = 16'h0006;
	localparam word_t DEV_USED = 16'h001e;
	localparam word_t QCAL_USED = 16'h0006;
	localparam word_t QPOW_USED = 16'h01fe;
	localparam word_t QUESTIONABLE_GROUP_USED = 16'h0308;
	localparam word_t OPERATION_GROUP_USED = 16'h1c21;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ULF_LO = 3; // four window/measurement bits
	localparam int CALOP_LO = 1; // channel a, b calibrating
	localparam int DEV_PRES_LO = 1; // sensor present a, b
	localparam int DEV_ERR_LO = 3; // sensor error a, b
	localparam int QCAL_LO = 1; // zero/cal error a, b
	localparam int POW_OVL_LO = 1; // input overload ch1, ch2
	localparam int POW_ZERO_LO = 3; // zeroing needed a, b
	localparam int POW_INV_LO = 5; // invalid data / log error
	localparam int QUESTIONABLE_GROUP_POW_BIT = 3;
	localparam int QUESTIONABLE_GROUP_CAL_BIT = 8;
	localparam int QUESTIONABLE_GROUP_PST_BIT = 9;
	localparam int OPERATION_GROUP_CAL_BIT = 0;
	localparam int OPERATION_GROUP_TRIG_BIT = 5;
	localparam int OPERATION_GROUP_SENSE_BIT = 10;
	localparam int OPERATION_GROUP_LLF_BIT = 11;
	localparam int OPERATION_GROUP_ULF_BIT = 12;

	// ----------------------------------------
	// command and answer carriers
	// ----------------------------------------
	typedef struct packed {
		logic write; // 1 set, 0 query
		logic [2:0] group; // group select
		logic [2:0] field; // field select
		word_t wdata; // value already converted to binary
	} cmd_t;

	typedef struct packed {
		logic error; // command refused
		word_t rdata; // query answer
	} rsp_t;

endpackage

// *** scpi_status_reporting.sv ***
// Operation
// RULE1: upper limit fails on bits three to six
// RULE2: written values kept to fifteen bits
// RULE3: questionable shows power, calibration, self-test
// RULE4: calibration errors of a, b on bits 1-2
// RULE5: overload and zeroing-needed flags on bits 1-4
// RULE6: invalid data or log error, bits 5-8
// RULE7: device presence and sensor errors, bits 1-4
// RULE8: condition views are query only
// RULE9: device mask gates status byte bit one
// RULE10: event read returns value, then clears
// RULE11: falling filter latches true-to-false changes
// RULE12: rising filter latches false-to-true changes
// RULE13: calibrating condition per channel on bits 1-2
// RULE14: calibrating mask gates operation bit zero
// RULE15: decimal, binary, hex writes behave alike
// RULE16: host writes six for sensor detection reports
// RULE17: filtered condition transitions set event bits
// RULE18: upper limit summary on operation bit twelve
// RULE19: summary is or of masked events
`timescale 1ns/10ps
module scpi_status_reporting
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire scpi_status_pkg::cmd_t cmd,
	output logic rsp_valid,
	output scpi_status_pkg::rsp_t rsp,
	input wire logic [3:0] upper_limit_fail,
	input wire logic [1:0] calibrating,
	input wire logic [1:0] sensor_present,
	input wire logic [1:0] sensor_error,
	input wire logic [1:0] cal_error,
	input wire logic [1:0] input_overload,
	input wire logic [1:0] zero_needed,
	input wire logic [3:0] data_invalid,
	input wire logic self_test_fail,
	input wire logic trigger_summary,
	input wire logic sense_summary,
	input wire logic lower_limit_fail_summary,
	output logic device_summary,
	output logic questionable_summary,
	output logic operation_summary
);

	// ----------------------------------------
	// per-group storage
	// ----------------------------------------
	scpi_status_pkg::word_t condition_view [scpi_status_pkg::GROUPS]; // condition views
	scpi_status_pkg::word_t raw [scpi_status_pkg::GROUPS]; // unmasked sources
	scpi_status_pkg::word_t used [scpi_status_pkg::GROUPS]; // bits in use
	scpi_status_pkg::word_t prev_q [scpi_status_pkg::GROUPS]; // last condition
	scpi_status_pkg::word_t event_q [scpi_status_pkg::GROUPS]; // event latch
	scpi_status_pkg::word_t mask_q [scpi_status_pkg::GROUPS]; // event mask
	scpi_status_pkg::word_t rise_q [scpi_status_pkg::GROUPS]; // rising filter
	scpi_status_pkg::word_t fall_q [scpi_status_pkg::GROUPS]; // falling filter
	scpi_status_pkg::word_t ev_set [scpi_status_pkg::GROUPS]; // new events
	logic [scpi_status_pkg::GROUPS-1:0] summ; // group summaries

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	wire logic grp_ok = cmd.group < 3'(scpi_status_pkg::GROUPS); // known group
	wire logic fld_ok = cmd.field <= scpi_status_pkg::FLD_FALL; // known field
	// writes to condition or event are refused, not stored
	wire logic wr_ro = cmd.write &&
		(cmd.field == scpi_status_pkg::FLD_CONDITION_VIEW ||
		cmd.field == scpi_status_pkg::FLD_EVENT); // RULE8 RULE10
	wire logic cmd_err = !grp_ok || !fld_ok || wr_ro;
	wire logic cmd_do = cmd_valid && !cmd_err; // accepted command
	wire logic do_wr = cmd_do && cmd.write;
	wire logic do_rd = cmd_do && !cmd.write;
	// value arrives as plain binary; radix parsing lives upstream
	wire scpi_status_pkg::word_t wr_val =
		cmd.wdata & scpi_status_pkg::WRITE_KEEP; // RULE2 RULE15
	wire logic [2:0] gsel = grp_ok ? cmd.group : 3'h0; // safe index

	// ----------------------------------------
	// condition sources
	// ----------------------------------------
	// each group's live inputs, placed at their bit positions
	always_comb
	begin
		for (int g = 0; g < scpi_status_pkg::GROUPS; g++)
		begin
			raw[g] = '0;
		end
		raw[scpi_status_pkg::GRP_ULF][scpi_status_pkg::ULF_LO +: 4] =
			upper_limit_fail; // RULE1
		raw[scpi_status_pkg::GRP_CALOP][scpi_status_pkg::CALOP_LO +: 2] =
			calibrating; // RULE13
		raw[scpi_status_pkg::GRP_DEV][scpi_status_pkg::DEV_PRES_LO +: 2] =
			sensor_present; // RULE7
		raw[scpi_status_pkg::GRP_DEV][scpi_status_pkg::DEV_ERR_LO +: 2] =
			sensor_error; // RULE7
		raw[scpi_status_pkg::GRP_QCAL][scpi_status_pkg::QCAL_LO +: 2] =
			cal_error; // RULE4
		raw[scpi_status_pkg::GRP_QPOW][scpi_status_pkg::POW_OVL_LO +: 2] =
			input_overload; // RULE5
		raw[scpi_status_pkg::GRP_QPOW][scpi_status_pkg::POW_ZERO_LO +: 2] =
			zero_needed; // RULE5
		raw[scpi_status_pkg::GRP_QPOW][scpi_status_pkg::POW_INV_LO +: 4] =
			data_invalid; // RULE6
		// summary groups take lower summaries as conditions
		raw[scpi_status_pkg::GRP_QUESTIONABLE_GROUP][scpi_status_pkg::QUESTIONABLE_GROUP_POW_BIT] =
			summ[scpi_status_pkg::GRP_QPOW]; // RULE3
		raw[scpi_status_pkg::GRP_QUESTIONABLE_GROUP][scpi_status_pkg::QUESTIONABLE_GROUP_CAL_BIT] =
			summ[scpi_status_pkg::GRP_QCAL]; // RULE3
		raw[scpi_status_pkg::GRP_QUESTIONABLE_GROUP][scpi_status_pkg::QUESTIONABLE_GROUP_PST_BIT] =
			self_test_fail; // RULE3
		raw[scpi_status_pkg::GRP_OPERATION_GROUP][scpi_status_pkg::OPERATION_GROUP_CAL_BIT] =
			summ[scpi_status_pkg::GRP_CALOP]; // RULE14
		raw[scpi_status_pkg::GRP_OPERATION_GROUP][scpi_status_pkg::OPERATION_GROUP_TRIG_BIT] =
			trigger_summary;
		raw[scpi_status_pkg::GRP_OPERATION_GROUP][scpi_status_pkg::OPERATION_GROUP_SENSE_BIT] =
			sense_summary;
		raw[scpi_status_pkg::GRP_OPERATION_GROUP][scpi_status_pkg::OPERATION_GROUP_LLF_BIT] =
			lower_limit_fail_summary;
		raw[scpi_status_pkg::GRP_OPERATION_GROUP][scpi_status_pkg::OPERATION_GROUP_ULF_BIT] =
			summ[scpi_status_pkg::GRP_ULF]; // RULE18
	end

	// unused bits and the top bit never reach the views
	assign used[scpi_status_pkg::GRP_ULF] = scpi_status_pkg::ULF_USED;
	assign used[scpi_status_pkg::GRP_CALOP] = scpi_status_pkg::CALOP_USED;
	assign used[scpi_status_pkg::GRP_DEV] = scpi_status_pkg::DEV_USED;
	assign used[scpi_status_pkg::GRP_QCAL] = scpi_status_pkg::QCAL_USED;
	assign used[scpi_status_pkg::GRP_QPOW] = scpi_status_pkg::QPOW_USED;
	assign used[scpi_status_pkg::GRP_QUESTIONABLE_GROUP] = scpi_status_pkg::QUESTIONABLE_GROUP_USED;
	assign used[scpi_status_pkg::GRP_OPERATION_GROUP] = scpi_status_pkg::OPERATION_GROUP_USED;

	// ----------------------------------------
	// per-group filter, latch and summary
	// ----------------------------------------
	for (genvar g = 0; g < scpi_status_pkg::GROUPS; g++)
	begin : grp
		wire logic hit = cmd.group == 3'(g); // this group addressed
		wire logic wr_mask = do_wr && hit &&
			cmd.field == scpi_status_pkg::FLD_MASK;
		wire logic wr_rise = do_wr && hit &&
			cmd.field == scpi_status_pkg::FLD_RISE;
		wire logic wr_fall = do_wr && hit &&
			cmd.field == scpi_status_pkg::FLD_FALL;
		wire logic rd_clr = do_rd && hit &&
			cmd.field == scpi_status_pkg::FLD_EVENT; // RULE10

		assign condition_view[g] = raw[g] & used[g] & scpi_status_pkg::WRITE_KEEP; // RULE2
		// edges picked by the filters become events
		assign ev_set[g] = (condition_view[g] & ~prev_q[g] & rise_q[g]) | // RULE12 RULE17
			(~condition_view[g] & prev_q[g] & fall_q[g]); // RULE11 RULE17
		assign summ[g] = |(event_q[g] & mask_q[g]); // RULE19 RULE9 RULE14

		// last condition, for edge detection
		// a condition already high at release counts as a rising edge
		always_ff @(posedge sys_clk or posedge sys_rst)
		begin
			if (sys_rst)
				prev_q[g] <= '0;
			else
				prev_q[g] <= condition_view[g];
		end

		// event latch: a new event wins over a clearing read
		always_ff @(posedge sys_clk or posedge sys_rst)
		begin
			if (sys_rst)
				event_q[g] <= scpi_status_pkg::EVENT_RST;
			else
				event_q[g] <= (rd_clr ? '0 : event_q[g]) | ev_set[g]; // RULE10
		end

		// software writable mask and filters, top bit forced low
		always_ff @(posedge sys_clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				mask_q[g] <= scpi_status_pkg::MASK_RST;
				rise_q[g] <= scpi_status_pkg::RISE_RST;
				fall_q[g] <= scpi_status_pkg::FALL_RST;
			end
			else
			begin
				if (wr_mask)
					mask_q[g] <= wr_val; // RULE2
				if (wr_rise)
					rise_q[g] <= wr_val; // RULE2
				if (wr_fall)
					fall_q[g] <= wr_val; // RULE2
			end
		end
	end

	// ----------------------------------------
	// query answer path
	// ----------------------------------------
	// selected field of the addressed group
	wire scpi_status_pkg::word_t rd_word =
		(cmd.field == scpi_status_pkg::FLD_CONDITION_VIEW) ? condition_view[gsel] :
		(cmd.field == scpi_status_pkg::FLD_EVENT) ? event_q[gsel] :
		(cmd.field == scpi_status_pkg::FLD_MASK) ? mask_q[gsel] :
		(cmd.field == scpi_status_pkg::FLD_RISE) ? rise_q[gsel] :
		fall_q[gsel];

	// answer one cycle after every command, error or not
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rsp_valid <= 1'b0;
			rsp <= '0;
		end
		else
		begin
			rsp_valid <= cmd_valid;
			if (cmd_valid)
			begin
				rsp.error <= cmd_err; // RULE8
				rsp.rdata <= do_rd ? rd_word : '0; // RULE10
			end
		end
	end

	// ----------------------------------------
	// summaries passed upward
	// ----------------------------------------
	assign device_summary = summ[scpi_status_pkg::GRP_DEV]; // RULE9
	assign questionable_summary = summ[scpi_status_pkg::GRP_QUESTIONABLE_GROUP];
	assign operation_summary = summ[scpi_status_pkg::GRP_OPERATION_GROUP];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// device-group event read and edge shapes, plus an upper limit fall with its filter off
	sequence s_dev_event_read;
		cmd_valid && !cmd.write && cmd.group == scpi_status_pkg::GRP_DEV &&
			cmd.field == scpi_status_pkg::FLD_EVENT;
	endsequence
	sequence s_dev_rise_a;
		!condition_view[scpi_status_pkg::GRP_DEV][1] ##1
			condition_view[scpi_status_pkg::GRP_DEV][1] &&
			rise_q[scpi_status_pkg::GRP_DEV][1];
	endsequence
	sequence s_dev_fall_a;
		condition_view[scpi_status_pkg::GRP_DEV][1] ##1
			!condition_view[scpi_status_pkg::GRP_DEV][1] &&
			fall_q[scpi_status_pkg::GRP_DEV][1];
	endsequence
	sequence s_ulf_fall_off;
		condition_view[scpi_status_pkg::GRP_ULF][3] ##1
			!condition_view[scpi_status_pkg::GRP_ULF][3] &&
			!fall_q[scpi_status_pkg::GRP_ULF][3];
	endsequence

	a_ulf_bit_map: assert property ( // RULE1
		condition_view[scpi_status_pkg::GRP_ULF] == {9'h000, upper_limit_fail, 3'h0})
		else $error("upper limit fail bits misplaced");
	a_top_bit_low: assert property ( // RULE2
		rsp_valid |-> !rsp.rdata[15])
		else $error("top bit of an answer is set");
	a_mask_write_keep: assert property ( // RULE2
		cmd_valid && cmd.write && cmd.group == scpi_status_pkg::GRP_DEV &&
		cmd.field == scpi_status_pkg::FLD_MASK |=>
		mask_q[scpi_status_pkg::GRP_DEV] == ($past(cmd.wdata) & 16'h7fff))
		else $error("mask write not stored as fifteen bits");
	a_questionable_group_map: assert property ( // RULE3
		condition_view[scpi_status_pkg::GRP_QUESTIONABLE_GROUP] ==
		{6'h00, self_test_fail, summ[scpi_status_pkg::GRP_QCAL], 4'h0,
		summ[scpi_status_pkg::GRP_QPOW], 3'h0})
		else $error("questionable summary bits misplaced");
	a_qcal_map: assert property ( // RULE4
		condition_view[scpi_status_pkg::GRP_QCAL] == {13'h0000, cal_error, 1'b0})
		else $error("calibration error bits misplaced");
	a_pow_low_map: assert property ( // RULE5
		condition_view[scpi_status_pkg::GRP_QPOW][4:0] ==
		{zero_needed, input_overload, 1'b0})
		else $error("overload or zeroing bits misplaced");
	a_pow_inv_map: assert property ( // RULE6
		condition_view[scpi_status_pkg::GRP_QPOW][15:5] == {7'h00, data_invalid})
		else $error("invalid data bits misplaced");
	a_dev_map: assert property ( // RULE7
		condition_view[scpi_status_pkg::GRP_DEV] ==
		{11'h000, sensor_error, sensor_present, 1'b0})
		else $error("device condition bits misplaced");
	a_condition_view_write_refused: assert property ( // RULE8
		cmd_valid && cmd.write && cmd.field == scpi_status_pkg::FLD_CONDITION_VIEW
		|=> rsp_valid && rsp.error)
		else $error("condition write not refused");
	a_dev_summary_gate: assert property ( // RULE9
		device_summary == |(event_q[scpi_status_pkg::GRP_DEV] &
		mask_q[scpi_status_pkg::GRP_DEV]))
		else $error("device summary not gated by mask");
	a_event_read_clear: assert property ( // RULE10
		s_dev_event_read ##0 ev_set[scpi_status_pkg::GRP_DEV] == '0 |=>
		rsp.rdata == $past(event_q[scpi_status_pkg::GRP_DEV]) &&
		event_q[scpi_status_pkg::GRP_DEV] == '0)
		else $error("event read did not return and clear");
	a_fall_latch: assert property ( // RULE11
		s_dev_fall_a |=> event_q[scpi_status_pkg::GRP_DEV][1])
		else $error("falling edge not latched");
	a_rise_latch: assert property ( // RULE12
		s_dev_rise_a |=> event_q[scpi_status_pkg::GRP_DEV][1])
		else $error("rising edge not latched");
	a_calop_map: assert property ( // RULE13
		condition_view[scpi_status_pkg::GRP_CALOP] == {13'h0000, calibrating, 1'b0})
		else $error("calibrating bits misplaced");
	a_operation_group_cal_bit: assert property ( // RULE14
		condition_view[scpi_status_pkg::GRP_OPERATION_GROUP][0] ==
		|(event_q[scpi_status_pkg::GRP_CALOP] &
		mask_q[scpi_status_pkg::GRP_CALOP]))
		else $error("operation bit zero not calibrating summary");
	a_operation_group_ulf_bit: assert property ( // RULE18
		condition_view[scpi_status_pkg::GRP_OPERATION_GROUP][12] == summ[scpi_status_pkg::GRP_ULF])
		else $error("operation bit twelve not limit summary");
	a_no_edge_no_set: assert property ( // RULE17
		$stable(condition_view[scpi_status_pkg::GRP_ULF]) |->
		ev_set[scpi_status_pkg::GRP_ULF] == '0 || $past(sys_rst))
		else $error("event set without a transition");
	// event latches take no writes
	a_event_write_refused: assert property ( // RULE10
		cmd_valid && cmd.write && cmd.field == scpi_status_pkg::FLD_EVENT
		|=> rsp_valid && rsp.error)
		else $error("event write not refused");
	// a condition query answers the view at its taking edge
	a_condition_view_query_value: assert property ( // RULE8
		cmd_valid && !cmd.write && cmd.group == scpi_status_pkg::GRP_DEV &&
		cmd.field == scpi_status_pkg::FLD_CONDITION_VIEW |=>
		rsp.rdata == $past(condition_view[scpi_status_pkg::GRP_DEV]))
		else $error("condition query answer wrong");
	// a refused condition write leaves the device group's mask and filters as they were
	a_refused_no_store: assert property ( // RULE8
		cmd_valid && cmd.write && cmd.group == scpi_status_pkg::GRP_DEV &&
		cmd.field == scpi_status_pkg::FLD_CONDITION_VIEW |=>
		$stable(mask_q[scpi_status_pkg::GRP_DEV]) &&
		$stable(rise_q[scpi_status_pkg::GRP_DEV]) &&
		$stable(fall_q[scpi_status_pkg::GRP_DEV]))
		else $error("refused write changed a register");
	// a fall with its filter bit clear must not add an event
	a_fall_filter_off: assert property ( // RULE11
		s_ulf_fall_off |=>
		!event_q[scpi_status_pkg::GRP_ULF][3] ||
		$past(event_q[scpi_status_pkg::GRP_ULF][3]))
		else $error("falling edge latched with its filter off");
	// no store ever keeps the top bit, whatever the host sent
	a_filters_top_low: assert property ( // RULE2
		!mask_q[scpi_status_pkg::GRP_DEV][15] &&
		!rise_q[scpi_status_pkg::GRP_DEV][15] &&
		!fall_q[scpi_status_pkg::GRP_DEV][15])
		else $error("top bit kept in a mask or filter");

endmodule // scpi_status_reporting

// *** status_host.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// remote host model, one command at a time
// ----------------------------------------
module status_host
(
	input wire logic sys_clk,
	output logic cmd_valid,
	output scpi_status_pkg::cmd_t cmd,
	input wire logic rsp_valid,
	input wire scpi_status_pkg::rsp_t rsp
);
	// idle bus at time zero
	initial
	begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// strobe one cycle, then take the answer one cycle later
	task automatic send(input logic w, input logic [2:0] g,
		input logic [2:0] f, input logic [15:0] d,
		output scpi_status_pkg::rsp_t r, output logic on_time);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd <= '{w, g, f, d};
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		// stale fields are scrambled so nothing leans on them
		cmd <= '{1'b0, ~g, ~f, ~d};
		@(posedge sys_clk);
		on_time = rsp_valid;
		r = rsp;
	endtask
endmodule // status_host

// *** tb_scpi_status_reporting.sv ***
`timescale 1ns/10ps
module tb_scpi_status_reporting;
	logic sys_clk;
	logic sys_rst;
	logic cmd_valid;
	scpi_status_pkg::cmd_t cmd;
	logic rsp_valid;
	scpi_status_pkg::rsp_t rsp;
	logic [23:0] lv; // all condition inputs in one vector
	logic dev_sum;
	logic questionable_group_sum;
	logic operation_group_sum;
	int num_errors;
	int n_checks;
	// model state per group code
	int cnd[7], prv[7], ev[7], msk[7], rse[7], fll[7];
	logic [31:0] seed;

	// ----------------------------------------
	// design and host
	// ----------------------------------------
	scpi_status_reporting u_scpi_status_reporting (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.rsp_valid(rsp_valid), .rsp(rsp), .upper_limit_fail(lv[3:0]),
		.calibrating(lv[5:4]), .sensor_present(lv[7:6]),
		.sensor_error(lv[9:8]), .cal_error(lv[11:10]),
		.input_overload(lv[13:12]), .zero_needed(lv[15:14]),
		.data_invalid(lv[19:16]), .self_test_fail(lv[20]),
		.trigger_summary(lv[21]), .sense_summary(lv[22]),
		.lower_limit_fail_summary(lv[23]), .device_summary(dev_sum),
		.questionable_summary(questionable_group_sum), .operation_summary(operation_group_sum));
	status_host u_status_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
		.cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string msg);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %s seen %h expected %h",
				$time, msg, seen, exp);
		end
	endtask

	function automatic int summ(input int g);
		return ((ev[g] & msk[g]) != 0) ? 1 : 0;
	endfunction

	// edge filters latch into events, then condition becomes history
	task automatic upd(input int g);
		ev[g] |= ((rse[g] & ~prv[g] & cnd[g]) |
			(fll[g] & prv[g] & ~cnd[g])) & 32'h7fff;
		prv[g] = cnd[g];
	endtask

	// settled model update, leaves first, parents after
	task automatic step();
		cnd[0] = int'(lv[3:0]) << 3;
		cnd[1] = int'(lv[5:4]) << 1;
		cnd[2] = (int'(lv[7:6]) << 1) | (int'(lv[9:8]) << 3);
		cnd[3] = int'(lv[11:10]) << 1;
		cnd[4] = (int'(lv[13:12]) << 1) | (int'(lv[15:14]) << 3) |
			(int'(lv[19:16]) << 5);
		for (int g = 0; g < 5; g++)
			upd(g);
		cnd[5] = (summ(4) << 3) | (summ(3) << 8) | (int'(lv[20]) << 9);
		upd(5);
		cnd[6] = summ(1) | (int'(lv[21]) << 5) | (int'(lv[22]) << 10) |
			(int'(lv[23]) << 11) | (summ(0) << 12);
		upd(6);
	endtask

	// let the chain settle, then compare summary outputs
	task automatic settle();
		repeat (6) @(posedge sys_clk);
		step();
		check(16'(dev_sum), 16'(summ(2)), "device summary");
		check(16'(questionable_group_sum), 16'(summ(5)), "questionable_group summary");
		check(16'(operation_group_sum), 16'(summ(6)), "operation_group summary");
	endtask

	// one command against the model
	task automatic run(input logic w, input int g, input int f,
		input logic [15:0] d);
		scpi_status_pkg::rsp_t r;
		logic ot;
		int e;
		int rd;
		e = 0;
		rd = 0;
		u_status_host.send(w, 3'(g), 3'(f), d, r, ot);
		if (g > 6 || f > 4 || (w && f < 2))
			e = 1;
		else if (w && f == 2)
			msk[g] = d & 16'h7fff;
		else if (w && f == 3)
			rse[g] = d & 16'h7fff;
		else if (w)
			fll[g] = d & 16'h7fff;
		else if (f == 0)
			rd = cnd[g];
		else if (f == 1)
		begin
			rd = ev[g];
			ev[g] = 0;
		end
		else
			rd = (f == 2) ? msk[g] : ((f == 3) ? rse[g] : fll[g]);
		check(16'(ot), 16'h0001, "answer strobe");
		check(16'(r.error), 16'(e), "error flag");
		check(r.rdata, 16'(rd), "read data");
		settle();
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// watchdog, about four and a half times the expected run
	// ----------------------------------------
	initial
	begin
		#200000;
		num_errors++;
		report_and_stop();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		num_errors = 0;
		n_checks = 0;
		seed = 32'h0001_74ac;
		sys_rst = 1'b1;
		lv = '0;
		for (int g = 0; g < 7; g++)
		begin
			{cnd[g], prv[g], ev[g], msk[g], fll[g]} = '0;
			rse[g] = 32'h7fff;
		end
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// reset values of masks and filters
		for (int g = 0; g < 7; g++)
			for (int f = 2; f < 5; f++)
				run(1'b0, g, f, 16'h0000);
		$display("test reset values done");
		// refused writes and bad codes change nothing
		for (int g = 0; g < 7; g++)
		begin
			run(1'b1, g, 0, 16'h0006);
			run(1'b1, g, 1, 16'h0006);
		end
		run(1'b0, 7, 0, 16'h0000);
		run(1'b0, 2, 5, 16'h0000);
		$display("test refusals done");
		// top bit dropped, then sensor detection reporting
		run(1'b1, 2, 2, 16'hffff);
		run(1'b0, 2, 2, 16'h0000);
		run(1'b1, 2, 2, 16'h0006);
		run(1'b1, 2, 4, 16'h0006);
		@(posedge sys_clk);
		lv[7:6] <= 2'h3;
		settle();
		run(1'b0, 2, 1, 16'h0000);
		run(1'b0, 2, 1, 16'h0000);
		@(posedge sys_clk);
		lv[7:6] <= 2'h1;
		settle();
		run(1'b0, 2, 1, 16'h0000);
		$display("test device group done");
		// random conditions, filters and masks
		for (int i = 0; i < 60; i++)
		begin
			seed = lfsr(seed);
			@(posedge sys_clk);
			lv <= seed[23:0];
			settle();
			seed = lfsr(seed);
			// host keeps field codes and data within range, group code can reach seven
			run(seed[0], int'(seed[3:1]), int'(seed[6:4]) % 5,
				seed[31:16] & 16'h7fff);
			for (int g = 0; g < 7; g++)
			begin
				run(1'b0, g, 0, 16'h0000);
				run(1'b0, g, 1, 16'h0000);
			end
		end
		$display("test random traffic done");
		report_and_stop();
	end
endmodule // tb_scpi_status_reporting
